// >>> include/sdc_pkg.sv
/*
  Shared constants, types and the command decoder for the synchronous DRAM
  command front end. Assumes a single 200 MHz clock shared with the controller.
*/
`default_nettype none

package sdc_pkg;

  // ==========================================================================
  // Widths and pin fields
  // ==========================================================================
  localparam int ADDR_W = 12;
  localparam int COL_W = 8;
  localparam int BANK_W = 2;
  localparam int BANKS = 4;
  localparam int DATA_W = 16;
  localparam int PRE_ALL_BIT = 10;
  localparam int FIFO_DEPTH = 4;
  localparam int MASK_LATENCY = 2;

  // ==========================================================================
  // Timing, in printed units, then in clock cycles
  // ==========================================================================
  localparam int CLK_PERIOD_PS = 5000;
  localparam int POWERUP_PAUSE_US = 200;
  localparam int ACT_TO_RW_NS = 20;
  localparam int ACT_CYCLE_NS = 60;
  localparam int BANK_TO_BANK_NS = 12;
  localparam int MODE_SET_RECOVERY_NS = 10;
  localparam int ACTIVE_HOLD_NS = 100000;
  // Least times round up, the longest hold rounds down
  localparam int POWERUP_PAUSE_CYC = (POWERUP_PAUSE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACT_TO_RW_CYC = (ACT_TO_RW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACT_CYCLE_CYC = (ACT_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int BANK_TO_BANK_CYC = (BANK_TO_BANK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MODE_SET_RECOVERY_CYC = (MODE_SET_RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACTIVE_HOLD_CYC = (ACTIVE_HOLD_NS * 1000) / CLK_PERIOD_PS;
  localparam int INIT_REFRESH_COUNT = 8;

  // ==========================================================================
  // Reset values and error flag positions
  // ==========================================================================
  localparam logic [ADDR_W-1:0] MODE_REG_RESET = 12'h000;
  localparam int ERR_INIT = 0;
  localparam int ERR_EARLY_RW = 1;
  localparam int ERR_REACT = 2;
  localparam int ERR_B2B = 3;
  localparam int ERR_HOLD = 4;
  localparam int ERR_MODE_SET = 5;
  localparam int ERR_RECOVERY = 6;
  localparam int ERR_OVERFLOW = 7;

  // ==========================================================================
  // Enumerations
  // ==========================================================================
  typedef enum logic [3:0] {
    CMD_DESELECT = 4'h0, CMD_IDLE = 4'h1, CMD_ACT = 4'h2, CMD_READ = 4'h3,
    CMD_WRITE = 4'h4, CMD_PRE = 4'h5, CMD_REFRESH = 4'h6, CMD_MODE = 4'h7, CMD_BSTOP = 4'h8
  } sdc_cmd_type;

  typedef enum logic [1:0] {
    INIT_PAUSE = 2'h0, INIT_PRECHARGE = 2'h1, INIT_PROGRAM = 2'h3, INIT_READY = 2'h2
  } sdc_init_type;

  typedef enum logic [1:0] {
    PWR_RUN = 2'h0, PWR_DOWN = 2'h1, PWR_SUSPEND = 2'h3, PWR_SELF = 2'h2
  } sdc_pwr_type;

  // Strobe combination to operation; chip select high masks everything
  function automatic sdc_cmd_type cmd_decode(input logic cs_n, input logic ras_n,
                                             input logic cas_n, input logic we_n);
    sdc_cmd_type c;
    c = CMD_IDLE;
    if (cs_n) begin
      c = CMD_DESELECT;
    end else begin
      unique case ({ras_n, cas_n, we_n})
        3'h7: c = CMD_IDLE;
        3'h3: c = CMD_ACT;
        3'h5: c = CMD_READ;
        3'h4: c = CMD_WRITE;
        3'h2: c = CMD_PRE;
        3'h1: c = CMD_REFRESH;
        3'h0: c = CMD_MODE;
        3'h6: c = CMD_BSTOP;
      endcase
    end
    return c;
  endfunction : cmd_decode

endpackage : sdc_pkg

`default_nettype wire

// >>> hw/sdc_fifo.sv
/*
  Write data FIFO between the pins and the array write port.
  Assumes DEPTH is a power of two and both sides share one clock.
*/
`timescale 1ns/1ps
`default_nettype none

module sdc_fifo import sdc_pkg::*; #(
  parameter int WIDTH = 40,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  // ==========================================================================
  // Pointers with one wrap bit
  // ==========================================================================
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic push, pop;

  // Full when pointers differ only in the wrap bit
  assign in_ready_o = !((wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]));
  assign out_valid_o = (wr_ptr_r != rd_ptr_r);
  assign out_data_o = mem_r[rd_ptr_r[AW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Pointer advance
  always_comb begin
    wr_ptr_nxt = push ? wr_ptr_r + (AW+1)'(1) : wr_ptr_r;
    rd_ptr_nxt = pop ? rd_ptr_r + (AW+1)'(1) : rd_ptr_r;
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
    end
  end

  // Storage has no reset; empty flag guards stale words
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
    end
  end

endmodule : sdc_fifo

`default_nettype wire

// >>> hw/sdc_bank.sv
/*
  One bank's open/closed state, latched row and interval checks.
  Assumes the caller decodes commands and presents one-cycle strobes.
*/
`timescale 1ns/1ps
`default_nettype none

module sdc_bank import sdc_pkg::*; #(
  parameter int CNT_W = 16,
  parameter int HOLD_CYC = ACTIVE_HOLD_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Command strobes for this bank
  input wire logic act_i,
  input wire logic pre_i,
  input wire logic rw_i,
  input wire logic [ADDR_W-1:0] row_i,
  // State and checks
  output logic open_o,
  output logic [ADDR_W-1:0] row_o,
  output logic rw_early_o,
  output logic reissue_o,
  output logic hold_over_o
);

  localparam logic [CNT_W-1:0] RCD_LIM = CNT_W'(ACT_TO_RW_CYC);
  localparam logic [CNT_W-1:0] RC_LIM = CNT_W'(ACT_CYCLE_CYC);
  localparam logic [CNT_W-1:0] HOLD_LIM = CNT_W'(HOLD_CYC);

  // ==========================================================================
  // Age counts edges since activate; 1 on the edge after it
  // ==========================================================================
  logic open_r, open_nxt, used_r, used_nxt;
  logic [ADDR_W-1:0] row_r, row_nxt;
  logic [CNT_W-1:0] age_r, age_nxt;

  always_comb begin
    open_nxt = open_r;
    used_nxt = used_r;
    row_nxt = row_r;
    age_nxt = (&age_r) ? age_r : age_r + CNT_W'(1); // Saturates, never wraps
    if (act_i) begin
      open_nxt = 1'b1;
      used_nxt = 1'b1;
      row_nxt = row_i; // see RULE25
      age_nxt = CNT_W'(1);
    end else if (pre_i) begin
      open_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      open_r <= 1'b0;
      used_r <= 1'b0;
      row_r <= '0;
      age_r <= '0;
    end else begin
      open_r <= open_nxt;
      used_r <= used_nxt;
      row_r <= row_nxt;
      age_r <= age_nxt;
    end
  end

  // Interval checks against the controller's obligations
  assign rw_early_o = rw_i && (!open_r || age_r < RCD_LIM); // see RULE18
  assign reissue_o = act_i && (open_r || (used_r && age_r < RC_LIM)); // see RULE19 see RULE20
  assign hold_over_o = open_r && (age_r > HOLD_LIM); // see RULE22
  assign open_o = open_r;
  assign row_o = row_r;

endmodule : sdc_bank

`default_nettype wire

// >>> hw/sdc_front.sv
/*
  Command front end of a four-bank synchronous DRAM: pin decode, byte masks,
  clock gating, initialization tracking and bank activate bookkeeping.
  Assumes the controller drives the pins from this same clock, so the pins
  are sampled directly; the array core sits behind the read and write ports.
*/
// Summary of operation
// RULE1: Row on twelve pins, column on lower eight
// RULE2: Precharge scope bit high closes every bank
// RULE3: Bank select picks bank for activate, access
// RULE4: Chip select high ignores commands, work continues
// RULE5: Strobes sampled at rising edge select operation
// RULE6: Read mask high tristates byte two cycles later
// RULE7: Write mask high blocks byte same cycle
// RULE8: Clock gate low enters a low power mode
// RULE9: Mode register undefined until programmed
// RULE10: Only idle commands during supply ramp
// RULE11: Wait pause, then precharge all banks
// RULE12: Masks and clock gate high during pause
// RULE13: Mode register set after initial precharge
// RULE14: Eight refreshes before or after mode set
// RULE15: Mode set needs banks closed, gate high
// RULE16: All strobes low loads mode register
// RULE17: Wait recovery interval after mode set
// RULE18: Activate precedes access by the set delay
// RULE19: Precharge before reactivating the same bank
// RULE20: Same bank activates spaced by cycle time
// RULE21: Different bank activates spaced by delay
// RULE22: Bank must close before hold limit expires
// RULE23: Read command decode, start column on address
// RULE24: Write command decode, data in same cycle
// RULE25: Activate decode latches row and bank
// RULE26: Precharge and refresh command decodes
`timescale 1ns/1ps
`default_nettype none

module sdc_front import sdc_pkg::*; #(
  parameter int PAUSE_CYC = POWERUP_PAUSE_CYC,
  parameter int HOLD_CYC = ACTIVE_HOLD_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Command pins
  input wire logic clock_gate_i,
  input wire logic chip_select_n_i,
  input wire logic row_strobe_n_i,
  input wire logic column_strobe_n_i,
  input wire logic write_strobe_n_i,
  input wire logic [ADDR_W-1:0] addr_pins_i,
  input wire logic bank_sel_lo_i,
  input wire logic bank_sel_hi_i,
  input wire logic byte_mask_lower_i,
  input wire logic byte_mask_upper_i,
  // Data pins, one enable per byte
  input wire logic [DATA_W-1:0] data_io_i,
  output logic [DATA_W-1:0] data_io_o,
  output logic [1:0] data_io_oe_o,
  // Array read port
  output logic rd_req_o,
  output logic [BANK_W-1:0] rd_bank_o,
  output logic [ADDR_W-1:0] rd_row_o,
  output logic [COL_W-1:0] rd_col_o,
  input wire logic rd_valid_i,
  input wire logic [DATA_W-1:0] rd_data_i,
  // Array write port
  output logic wr_valid_o,
  input wire logic wr_ready_i,
  output logic [BANK_W-1:0] wr_bank_o,
  output logic [ADDR_W-1:0] wr_row_o,
  output logic [COL_W-1:0] wr_col_o,
  output logic [DATA_W-1:0] wr_data_o,
  output logic [1:0] wr_be_o,
  output logic write_ready_o,
  // Status
  output logic [ADDR_W-1:0] mode_reg_o,
  output logic mode_valid_o,
  output logic init_done_o,
  output logic [1:0] power_state_o,
  output logic [BANKS-1:0] banks_open_o,
  output logic [7:0] error_flags_o
);

  localparam int PAUSE_W = $clog2(PAUSE_CYC + 1);
  localparam int HOLD_W = $clog2(HOLD_CYC + 2);
  localparam int FIFO_W = 2 + BANK_W + ADDR_W + COL_W + DATA_W;
  localparam logic [PAUSE_W-1:0] PAUSE_LAST = PAUSE_W'(PAUSE_CYC);
  localparam logic [3:0] RECOVERY_LOAD = 4'(MODE_SET_RECOVERY_CYC);
  localparam logic [3:0] B2B_LIM = 4'(BANK_TO_BANK_CYC);
  localparam logic [3:0] REFRESH_TARGET = 4'(INIT_REFRESH_COUNT);

  // ==========================================================================
  // Command decode
  // ==========================================================================
  logic cke_r, cke_nxt;
  sdc_cmd_type cmd;
  logic [BANK_W-1:0] bank;
  logic busy_cmd, pre_all;

  // Clock gate sampled low suspends the next edge's decode
  assign cmd = cke_r ? cmd_decode(chip_select_n_i, row_strobe_n_i, column_strobe_n_i,
                                  write_strobe_n_i) : CMD_IDLE; // see RULE4 see RULE5 see RULE8
  assign bank = {bank_sel_hi_i, bank_sel_lo_i}; // see RULE3
  assign busy_cmd = (cmd != CMD_IDLE) && (cmd != CMD_DESELECT);
  assign pre_all = addr_pins_i[PRE_ALL_BIT];
  assign cke_nxt = clock_gate_i;

  // ==========================================================================
  // Bank trackers
  // ==========================================================================
  logic [BANKS-1:0] open_vec, early_vec, reissue_vec, hold_vec;
  logic [ADDR_W-1:0] row_vec [BANKS];

  for (genvar b = 0; b < BANKS; b++) begin : g_bank
    sdc_bank #(.CNT_W(HOLD_W), .HOLD_CYC(HOLD_CYC)) u_bank (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .act_i((cmd == CMD_ACT) && (bank == BANK_W'(b))), // see RULE25
      .pre_i((cmd == CMD_PRE) && (pre_all || bank == BANK_W'(b))), // see RULE2 see RULE26
      .rw_i(((cmd == CMD_READ) || (cmd == CMD_WRITE)) && (bank == BANK_W'(b))),
      .row_i(addr_pins_i), // see RULE1
      .open_o(open_vec[b]),
      .row_o(row_vec[b]),
      .rw_early_o(early_vec[b]),
      .reissue_o(reissue_vec[b]),
      .hold_over_o(hold_vec[b])
    );
  end

  // ==========================================================================
  // Write path: masks act on the command's own cycle
  // ==========================================================================
  logic [1:0] wr_be;
  logic fifo_in_valid, fifo_in_ready;
  logic [FIFO_W-1:0] fifo_out;

  assign wr_be = {!byte_mask_upper_i, !byte_mask_lower_i}; // see RULE7
  // A fully masked word is never queued; see RULE24
  assign fifo_in_valid = (cmd == CMD_WRITE) && (|wr_be) && fifo_in_ready;
  assign write_ready_o = fifo_in_ready;

  sdc_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i({wr_be, bank, row_vec[bank], addr_pins_i[COL_W-1:0], data_io_i}), // see RULE1
    .out_valid_o(wr_valid_o),
    .out_ready_i(wr_ready_i),
    .out_data_o(fifo_out)
  );
  assign {wr_be_o, wr_bank_o, wr_row_o, wr_col_o, wr_data_o} = fifo_out;

  // ==========================================================================
  // Read path and output drivers
  // ==========================================================================
  logic rd_req_r, rd_req_nxt;
  logic [BANK_W-1:0] rd_bank_r, rd_bank_nxt;
  logic [ADDR_W-1:0] rd_row_r, rd_row_nxt;
  logic [COL_W-1:0] rd_col_r, rd_col_nxt;
  logic [1:0] mask_d1_r, mask_d1_nxt, mask_d2_r, mask_d2_nxt;
  logic [1:0] oe_r, oe_nxt;
  logic [DATA_W-1:0] dout_r, dout_nxt;

  // Mask runs down a two-stage pipe so the drivers go quiet two cycles on
  always_comb begin
    rd_req_nxt = (cmd == CMD_READ); // see RULE23
    rd_bank_nxt = rd_req_nxt ? bank : rd_bank_r;
    rd_row_nxt = rd_req_nxt ? row_vec[bank] : rd_row_r;
    rd_col_nxt = rd_req_nxt ? addr_pins_i[COL_W-1:0] : rd_col_r; // see RULE1
    mask_d1_nxt = {byte_mask_upper_i, byte_mask_lower_i};
    mask_d2_nxt = mask_d1_r;
    oe_nxt = {2{rd_valid_i}} & ~mask_d2_r; // see RULE6
    dout_nxt = rd_valid_i ? rd_data_i : dout_r;
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_req_r <= 1'b0;
      rd_bank_r <= '0;
      rd_row_r <= '0;
      rd_col_r <= '0;
      mask_d1_r <= 2'h3;
      mask_d2_r <= 2'h3;
      oe_r <= 2'h0;
      dout_r <= '0;
    end else begin
      rd_req_r <= rd_req_nxt;
      rd_bank_r <= rd_bank_nxt;
      rd_row_r <= rd_row_nxt;
      rd_col_r <= rd_col_nxt;
      mask_d1_r <= mask_d1_nxt;
      mask_d2_r <= mask_d2_nxt;
      oe_r <= oe_nxt;
      dout_r <= dout_nxt;
    end
  end

  // ==========================================================================
  // Mode register, initialization and power state
  // ==========================================================================
  sdc_init_type init_r, init_nxt;
  sdc_pwr_type pwr_r, pwr_nxt;
  logic [ADDR_W-1:0] mode_r, mode_nxt;
  logic mode_valid_r, mode_valid_nxt;
  logic [PAUSE_W-1:0] pause_r, pause_nxt;
  logic [3:0] refresh_r, refresh_nxt, recov_r, recov_nxt, b2b_r, b2b_nxt;
  logic [BANK_W-1:0] last_bank_r, last_bank_nxt;
  logic [7:0] err_r, err_nxt;
  logic pause_done;

  assign pause_done = (pause_r == PAUSE_LAST);

  always_comb begin
    mode_nxt = mode_r;
    mode_valid_nxt = mode_valid_r;
    pause_nxt = pause_done ? pause_r : pause_r + PAUSE_W'(1);
    refresh_nxt = refresh_r;
    recov_nxt = (recov_r != 4'h0) ? recov_r - 4'h1 : recov_r;
    b2b_nxt = (&b2b_r) ? b2b_r : b2b_r + 4'h1;
    last_bank_nxt = last_bank_r;
    init_nxt = init_r;
    pwr_nxt = pwr_r;
    err_nxt = err_r;
    // Register contents are not trusted before the first load; see RULE9
    if (cmd == CMD_MODE) begin
      mode_nxt = addr_pins_i; // see RULE16
      mode_valid_nxt = 1'b1;
      recov_nxt = RECOVERY_LOAD;
    end
    if (cmd == CMD_ACT) begin
      last_bank_nxt = bank;
      b2b_nxt = 4'h1;
    end
    // Refresh with the gate low enters self refresh and does not count
    if ((cmd == CMD_REFRESH) && clock_gate_i && (init_r == INIT_PROGRAM) && (refresh_r != REFRESH_TARGET)) begin
      refresh_nxt = refresh_r + 4'h1; // see RULE14
    end
    unique case (init_r)
      INIT_PAUSE: if (pause_done) init_nxt = INIT_PRECHARGE; // see RULE11
      INIT_PRECHARGE: if ((cmd == CMD_PRE) && pre_all) init_nxt = INIT_PROGRAM;
      INIT_PROGRAM: if (mode_valid_r && (refresh_r == REFRESH_TARGET)) init_nxt = INIT_READY; // see RULE13
      INIT_READY: init_nxt = INIT_READY;
    endcase
    unique case (pwr_r)
      PWR_RUN: begin
        if (!clock_gate_i) begin
          pwr_nxt = (cmd == CMD_REFRESH) ? PWR_SELF : ((|open_vec) ? PWR_SUSPEND : PWR_DOWN); // see RULE8
        end
      end
      PWR_DOWN, PWR_SUSPEND, PWR_SELF: if (clock_gate_i) pwr_nxt = PWR_RUN;
    endcase
    // Sticky protocol flags; only reset clears them
    if ((init_r == INIT_PAUSE && busy_cmd) || (init_r != INIT_READY &&
        (cmd == CMD_ACT || cmd == CMD_READ || cmd == CMD_WRITE))) begin
      err_nxt[ERR_INIT] = 1'b1; // see RULE10 see RULE11
    end
    if (|early_vec) err_nxt[ERR_EARLY_RW] = 1'b1; // see RULE18
    if (|reissue_vec) err_nxt[ERR_REACT] = 1'b1; // see RULE19
    if ((cmd == CMD_ACT) && (bank != last_bank_r) && (b2b_r < B2B_LIM)) err_nxt[ERR_B2B] = 1'b1; // see RULE21
    if (|hold_vec) err_nxt[ERR_HOLD] = 1'b1; // see RULE22
    if ((cmd == CMD_MODE) && ((|open_vec) || !cke_r)) err_nxt[ERR_MODE_SET] = 1'b1; // see RULE15
    if (busy_cmd && (recov_r != 4'h0)) err_nxt[ERR_RECOVERY] = 1'b1; // see RULE17
    if ((cmd == CMD_WRITE) && (|wr_be) && !fifo_in_ready) err_nxt[ERR_OVERFLOW] = 1'b1;
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cke_r <= 1'b0;
      mode_r <= MODE_REG_RESET;
      mode_valid_r <= 1'b0;
      pause_r <= '0;
      refresh_r <= 4'h0;
      recov_r <= 4'h0;
      b2b_r <= 4'hf;
      last_bank_r <= '0;
      init_r <= INIT_PAUSE;
      pwr_r <= PWR_RUN;
      err_r <= 8'h00;
    end else begin
      cke_r <= cke_nxt;
      mode_r <= mode_nxt;
      mode_valid_r <= mode_valid_nxt;
      pause_r <= pause_nxt;
      refresh_r <= refresh_nxt;
      recov_r <= recov_nxt;
      b2b_r <= b2b_nxt;
      last_bank_r <= last_bank_nxt;
      init_r <= init_nxt;
      pwr_r <= pwr_nxt;
      err_r <= err_nxt;
    end
  end

  // Outputs
  assign data_io_o = dout_r;
  assign data_io_oe_o = oe_r;
  assign rd_req_o = rd_req_r;
  assign rd_bank_o = rd_bank_r;
  assign rd_row_o = rd_row_r;
  assign rd_col_o = rd_col_r;
  assign mode_reg_o = mode_r;
  assign mode_valid_o = mode_valid_r;
  assign init_done_o = (init_r == INIT_READY);
  assign power_state_o = pwr_r;
  assign banks_open_o = open_vec;
  assign error_flags_o = err_r;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  a_read_mask_hiz: assert property (byte_mask_lower_i |-> ##3 !data_io_oe_o[0]) // see RULE6
    else $error("read mask did not tristate lower byte");
  a_write_mask_block: assert property ((cmd == CMD_WRITE && byte_mask_lower_i && byte_mask_upper_i && !wr_valid_o)
    |=> !wr_valid_o) // see RULE7
    else $error("fully masked write was queued");
  a_deselect_ignored: assert property ((chip_select_n_i && !rd_req_o) |=> !rd_req_o && $stable(mode_reg_o)) // see RULE4
    else $error("deselected command took effect");
  a_act_opens_bank: assert property ((cmd == CMD_ACT) |=> banks_open_o[$past(bank)]) // see RULE25
    else $error("activate did not open bank");
  a_pre_all_closes: assert property ((cmd == CMD_PRE && pre_all && cke_r) |=> banks_open_o == 4'h0) // see RULE2
    else $error("precharge all left a bank open");
  a_mode_latch: assert property ((cmd == CMD_MODE) |=> mode_valid_o && mode_reg_o == $past(addr_pins_i)) // see RULE16
    else $error("mode register did not load address");
  a_read_column: assert property ((cmd == CMD_READ) |=> rd_req_o && rd_col_o == $past(addr_pins_i[COL_W-1:0])
    && rd_bank_o == $past(bank)) // see RULE1
    else $error("read request wrong column or bank");
  a_gate_low_sleep: assert property ((pwr_r == PWR_RUN && !clock_gate_i) |=> power_state_o != PWR_RUN) // see RULE8
    else $error("clock gate low did not leave run");
  a_ready_needs_init: assert property ($rose(init_done_o) |-> mode_valid_o && $past(refresh_r) == REFRESH_TARGET) // see RULE14
    else $error("init done before mode set and refreshes");

  c_mode_set: cover property (cmd == CMD_MODE ##1 mode_valid_o);
  c_masked_read: cover property (byte_mask_upper_i ##2 rd_valid_i ##1 data_io_oe_o == 2'h1);
  c_self_refresh: cover property (power_state_o == PWR_SELF);
  c_init_ready: cover property ($rose(init_done_o));

endmodule : sdc_front

`default_nettype wire

// >>> tb/sdc_ctrl_model.sv
/* Controller model driving the command pins.
   Assumes the device samples on the same sys_clk_i. */
`timescale 1ns/1ps
`default_nettype none
module sdc_ctrl_model (
  // Clock
  input wire logic sys_clk_i,
  // Pins, cmd_o = {cs_n, ras_n, cas_n, we_n}
  output logic gate_o,
  output logic [3:0] cmd_o,
  output logic [11:0] addr_o,
  output logic [1:0] bank_o,
  output logic [1:0] mask_o
);
  // ====================
  // Power-up: idle only, masks and gate high
  initial begin
    cmd_o = 4'h7;
    mask_o = 2'h3;
    gate_o = 1'b1;
    addr_o = 12'h000;
    bank_o = 2'h0;
  end
  // One command edge, then idle; k = {gate low, masks}
  task automatic cmd(input logic [3:0] c, input logic [11:0] a, input logic [1:0] b, input logic [2:0] k);
    @(posedge sys_clk_i);
    cmd_o <= c;
    addr_o <= a;
    bank_o <= b;
    {gate_o, mask_o} <= {~k[2], k[1:0]};
    @(posedge sys_clk_i);
    cmd_o <= 4'h7;
    {gate_o, mask_o} <= 3'h4;
    #1;
  endtask : cmd
endmodule : sdc_ctrl_model
`default_nettype wire

// >>> tb/sdc_tb.sv
/* Self-checking bench for sdc_front.
   Assumes sdc_ctrl_model drives the pins. */
`timescale 1ns/1ps
`default_nettype none
module testbench import sdc_pkg::*;;
  // ====================
  localparam logic [3:0] ACT = 4'h3, RD = 4'h5, WR = 4'h4, PRE = 4'h2, REF = 4'h1, MRS = 4'h0, IDL = 4'h7;
  int n_errors = 0;
  int num_checks = 0;
  logic sys_clk_i = 1'b0, reset_i = 1'b1, rdv = 1'b0, wrdy = 1'b0, gate, rqo, wv, wrr, mv, idn;
  logic [3:0] cmd, bko;
  logic [11:0] adr, rrow, mreg, wrow;
  logic [1:0] bs, msk, oe, rbk, wbe, pst, wbk;
  logic [15:0] din = 16'hbeef, dout, wdat;
  logic [7:0] rcol, wcol, errf;
  sdc_ctrl_model i_sdc_ctrl_model (.sys_clk_i(sys_clk_i), .gate_o(gate), .cmd_o(cmd), .addr_o(adr), .bank_o(bs),
    .mask_o(msk));
  sdc_front #(.PAUSE_CYC(20), .HOLD_CYC(200)) i_sdc_front (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .clock_gate_i(gate), .chip_select_n_i(cmd[3]), .row_strobe_n_i(cmd[2]), .column_strobe_n_i(cmd[1]),
    .write_strobe_n_i(cmd[0]), .addr_pins_i(adr), .bank_sel_lo_i(bs[0]), .bank_sel_hi_i(bs[1]),
    .byte_mask_lower_i(msk[0]), .byte_mask_upper_i(msk[1]), .data_io_i(din), .data_io_o(dout),
    .data_io_oe_o(oe), .rd_req_o(rqo), .rd_bank_o(rbk), .rd_row_o(rrow), .rd_col_o(rcol), .rd_valid_i(rdv),
    .rd_data_i(din), .wr_valid_o(wv), .wr_ready_i(wrdy), .wr_bank_o(wbk), .wr_row_o(wrow), .wr_col_o(wcol),
    .wr_data_o(wdat), .wr_be_o(wbe), .write_ready_o(wrr), .mode_reg_o(mreg), .mode_valid_o(mv),
    .init_done_o(idn), .power_state_o(pst), .banks_open_o(bko), .error_flags_o(errf));
  initial forever #2.5 sys_clk_i = ~sys_clk_i;
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  // Pause, precharge all, eight refreshes, mode set
  task automatic t_init;
    repeat (25) @(posedge sys_clk_i);
    i_sdc_ctrl_model.cmd(PRE, 12'h400, 2'h0, 3'h3);
    repeat (8) i_sdc_ctrl_model.cmd(REF, 12'h000, 2'h0, 3'h0);
    i_sdc_ctrl_model.cmd(MRS, 12'h023, 2'h0, 3'h0);
    chk("mode_reg", 16'h0023, mreg);
    repeat (2) @(posedge sys_clk_i);
    chk("mode_valid init_done", 16'h3, {mv, idn});
    $display("t_init done");
  endtask : t_init
  // Activate, deselected activate ignored, read at the least delay
  task automatic t_act_read;
    i_sdc_ctrl_model.cmd(ACT, 12'h5a3, 2'h1, 3'h0);
    chk("banks_open", 16'h2, bko);
    i_sdc_ctrl_model.cmd(4'hb, 12'h000, 2'h2, 3'h0);
    chk("banks_open", 16'h2, bko);
    i_sdc_ctrl_model.cmd(RD, 12'hf3c, 2'h1, 3'h0);
    chk("rd_req", 16'h1, rqo);
    chk("rd_bank_row", {2'h1, 12'h5a3}, {rbk, rrow});
    chk("rd_col", 16'h3c, rcol);
    $display("t_act_read done");
  endtask : t_act_read
  // Masked write, fill FIFO while stalled, then drain
  task automatic t_write;
    i_sdc_ctrl_model.cmd(WR, 12'h011, 2'h1, 3'h3);
    chk("wr_valid_masked", 16'h0, wv);
    i_sdc_ctrl_model.cmd(WR, 12'h011, 2'h1, 3'h1);
    chk("wr_data", 16'hbeef, wdat);
    chk("wr_be_col", {2'h2, 8'h11}, {wbe, wcol});
    chk("wr_bank_row", {2'h1, 12'h5a3}, {wbk, wrow});
    repeat (3) i_sdc_ctrl_model.cmd(WR, 12'h011, 2'h1, 3'h0);
    chk("write_ready", 16'h0, wrr);
    @(posedge sys_clk_i);
    wrdy <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    wrdy <= 1'b0;
    #1;
    chk("wr_valid write_ready", 16'h1, {wv, wrr});
    $display("t_write done");
  endtask : t_write
  // Lower mask two edges before read data, then unmasked
  task automatic t_read_mask;
    i_sdc_ctrl_model.cmd(IDL, 12'h000, 2'h1, 3'h1);
    @(posedge sys_clk_i);
    rdv <= 1'b1;
    @(posedge sys_clk_i);
    #1;
    chk("oe_masked", 16'h2, oe);
    @(posedge sys_clk_i);
    rdv <= 1'b0;
    #1;
    chk("oe_open", 16'h3, oe);
    chk("data_out", 16'hbeef, dout);
    $display("t_read_mask done");
  endtask : t_read_mask
  // Close all banks, then gate low with nothing open
  task automatic t_close;
    i_sdc_ctrl_model.cmd(PRE, 12'h400, 2'h0, 3'h0);
    chk("banks_open", 16'h0, bko);
    i_sdc_ctrl_model.cmd(IDL, 12'h000, 2'h0, 3'h4);
    chk("power_state", 16'h1, pst);
    chk("error_flags", 16'h0, errf);
    $display("t_close done");
  endtask : t_close
  // Activates too close together and onto an open bank must be flagged
  task automatic t_viol;
    i_sdc_ctrl_model.cmd(ACT, 12'h001, 2'h0, 3'h0);
    i_sdc_ctrl_model.cmd(ACT, 12'h002, 2'h2, 3'h0);
    i_sdc_ctrl_model.cmd(ACT, 12'h003, 2'h0, 3'h0);
    chk("error_flags", 16'h0c, errf);
    $display("t_viol done");
  endtask : t_viol
  initial begin
    repeat (20) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    t_init;
    t_act_read;
    t_write;
    t_read_mask;
    t_close;
    t_viol;
    wrap_up;
  end
  // Run should take about 100 cycles
  initial begin
    repeat (3000) @(posedge sys_clk_i);
    n_errors++;
    wrap_up;
  end
endmodule : testbench
`default_nettype wire
